// ===== shared/plc_tc_consts.svh
// Purpose: timing counts, widths and reset values of the timer and counter bank
// Assumes: mclk at 10 MHz
// Notes: definitions only
`ifndef PLC_TC_CONSTS_SVH
`define PLC_TC_CONSTS_SVH
`define CLK_HZ 10000000
`define TICK_MS 100
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
`define NUM_TIMERS 80
`define NUM_COUNTERS 40
`define VAL_W 16
`define TIMER_IDX_W 7
`define COUNTER_IDX_W 6
`define IMM_MAX 16'h7fff
`define CLEAR_VALUE 16'h0000
`define SET_RESET_VALUE 16'h0001
`endif

// ===== shared/plc_tc_pkg.sv
// Purpose: types shared by the timer and counter bank
// Assumes: constants come from plc_tc_consts.svh
// Notes: source select tells an immediate constant from a data register value
`include "plc_tc_consts.svh"
package plc_tc_pkg;
    typedef enum logic [0:0] {
        src_immediate = 1'b0,
        src_register = 1'b1
    } set_source_type;

    // One command from the scan executor
    typedef struct packed {
        logic valid;
        logic clear;
        logic load;
        set_source_type source;
        logic [`VAL_W-1:0] set_value;
        logic [`VAL_W-1:0] load_value;
    } cmd_type;
endpackage

// ===== rtl/tick_prescaler.sv
// Purpose: single-cycle enable every 100 ms from mclk
// Assumes: mclk at 10 MHz
// Notes: period is a parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
`include "plc_tc_consts.svh"
module tick_prescaler #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic reset,
    output logic tick
);
    logic [23:0] count_q;

    // Free-running divider, pulse on wrap
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_q <= 24'h000000;
            tick <= 1'b0;
        end else if (count_q == 24'(TICK_CYCLES - 1)) begin // R16
            count_q <= 24'h000000;
            tick <= 1'b1;
        end else begin
            count_q <= count_q + 24'h000001;
            tick <= 1'b0;
        end
    end

    a_tick_spacing: assert property (@(posedge mclk) disable iff (reset) // R16
        tick |=> !tick)
        else $error("tick lasted more than one cycle");
endmodule // tick_prescaler
`default_nettype wire

// ===== rtl/scan_sync.sv
// Purpose: two-flop synchroniser for a pin input
// Assumes: input is asynchronous to mclk
// Notes: first flop is read by the second only
`timescale 1ns/1ps
`default_nettype none
module scan_sync (
    input wire logic mclk,
    input wire logic reset,
    input wire logic pin,
    output logic level
);
    logic meta_q;

    // Plain double flop
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta_q <= 1'b0;
            level <= 1'b0;
        end else begin
            meta_q <= pin;
            level <= meta_q;
        end
    end
endmodule // scan_sync
`default_nettype wire

// ===== rtl/plc_timer_counter_bank.sv
// Purpose: bank of 100 ms timers and 16-bit up counters for the scan executor
// Assumes: one clock mclk; reset models power-up clearing
// Notes: counter contacts publish at scan end; timer contacts follow at once
// Notes: a negative register set value is reached by counting up through the wrap
// How it works
// R1 - Timers advance once per 100 ms tick
// R2 - Timer contact on when value equals set
// R3 - Set value from immediate or data register
// R4 - Counter adds one per rising count edge
// R5 - Sixteen-bit count; immediate set 0 to 32767
// R6 - At set value, edges ignored, value held
// R7 - Counter contact latches on until reset
// R8 - Reset clears count and contact off
// R9 - Counter contacts visible only after scan end
// R10 - Set zero acts like set one
// R11 - Loaded value above set snaps at edge
// R12 - Count wraps 32767 to -32768
// R13 - Immediate positive only; register may be signed
// R14 - Executor avoids special register ranges
// R15 - Power loss clears counter values
// R16 - Prescaler makes a 100 ms pulse
`timescale 1ns/1ps
`default_nettype none
`include "plc_tc_consts.svh"
module plc_timer_counter_bank
    import plc_tc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic reset,
    // Timer command: enable level and set value for one timer
    input wire logic timer_cmd_valid,
    input wire logic [`TIMER_IDX_W-1:0] timer_index,
    input wire logic timer_enable,
    input wire set_source_type timer_source,
    input wire logic [`VAL_W-1:0] timer_set_value,
    // Counter command for one counter
    input wire logic [`COUNTER_IDX_W-1:0] counter_index,
    input wire cmd_type counter_cmd,
    // Counting inputs from pins, one per counter
    input wire logic [`NUM_COUNTERS-1:0] count_pins,
    // End of program scan, same clock domain
    input wire logic scan_end,
    output logic [`NUM_TIMERS-1:0] timer_contacts,
    output logic [`NUM_COUNTERS-1:0] counter_contacts,
    output logic [`VAL_W-1:0] counter_value_out,
    output logic [`VAL_W-1:0] timer_value_out
);
    logic tick;
    logic [`NUM_COUNTERS-1:0] count_level;
    logic [`NUM_COUNTERS-1:0] count_prev_q;
    logic [`VAL_W-1:0] timer_val_q [`NUM_TIMERS];
    logic [`VAL_W-1:0] timer_set_q [`NUM_TIMERS];
    logic [`NUM_TIMERS-1:0] timer_run_q;
    logic [`VAL_W-1:0] count_val_q [`NUM_COUNTERS];
    logic [`VAL_W-1:0] count_set_q [`NUM_COUNTERS];
    logic [`NUM_COUNTERS-1:0] count_done_q;

    // Effective set value: immediates are masked positive to 15 bits, zero means one
    function automatic logic [`VAL_W-1:0] eff_set(input set_source_type src,
                                                 input logic [`VAL_W-1:0] v);
        logic [`VAL_W-1:0] r;
        r = v;
        if (src == src_immediate) begin
            r = v & `IMM_MAX; // R13 R5
        end
        if (r == `CLEAR_VALUE) begin
            r = 16'h0001; // R10
        end
        return r; // R3
    endfunction

    // Edge that lands on the target, or starts at or past it in the same sign half.
    // A value in the other sign half must climb, through the wrap if needed.
    // Without the sign test a negative value would snap at once to a positive target and never wrap.
    function automatic logic reached_set(input logic [`VAL_W-1:0] cur,
                                         input logic [`VAL_W-1:0] target);
        logic hit;
        hit = (cur + 16'h0001) == target; // R10
        if (cur[`VAL_W-1] == target[`VAL_W-1] && cur >= target) begin
            hit = 1'b1; // R11
        end
        return hit;
    endfunction

    tick_prescaler #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .mclk(mclk),
        .reset(reset),
        .tick(tick)
    );

    // Each count pin is asynchronous; synchronise before edge detection
    genvar g;
    generate
        for (g = 0; g < `NUM_COUNTERS; g++) begin : g_sync
            scan_sync u_sync (
                .mclk(mclk),
                .reset(reset),
                .pin(count_pins[g]),
                .level(count_level[g])
            );
        end
    endgenerate

    // Previous level for off-to-on detection
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_prev_q <= '0;
        end else begin
            count_prev_q <= count_level;
        end
    end

    // Timer enable and set values come from the executor's command
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            timer_run_q <= '0;
            for (int i = 0; i < `NUM_TIMERS; i++) begin
                timer_set_q[i] <= `SET_RESET_VALUE;
            end
        end else if (timer_cmd_valid) begin
            timer_run_q[timer_index] <= timer_enable;
            timer_set_q[timer_index] <= eff_set(timer_source, timer_set_value); // R3
        end
    end

    // Timer values climb on ticks until equal to set; disabled timers clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < `NUM_TIMERS; i++) begin
                timer_val_q[i] <= `CLEAR_VALUE;
            end
        end else begin
            for (int i = 0; i < `NUM_TIMERS; i++) begin
                if (!timer_run_q[i]) begin
                    timer_val_q[i] <= `CLEAR_VALUE;
                end else if (tick && timer_val_q[i] != timer_set_q[i]) begin
                    timer_val_q[i] <= timer_val_q[i] + 16'h0001; // R1
                end
            end
        end
    end

    // Timer contacts registered from the equality compare
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            timer_contacts <= '0;
        end else begin
            for (int i = 0; i < `NUM_TIMERS; i++) begin
                timer_contacts[i] <= timer_run_q[i] && timer_val_q[i] == timer_set_q[i]; // R2
            end
        end
    end

    // Counter set values latched from the command
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < `NUM_COUNTERS; i++) begin
                count_set_q[i] <= `SET_RESET_VALUE;
            end
        end else if (counter_cmd.valid) begin
            count_set_q[counter_index] <= eff_set(counter_cmd.source,
                                                  counter_cmd.set_value); // R3
        end
    end

    // Counter values and internal done flags; clear beats a same-cycle edge
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_done_q <= '0;
            for (int i = 0; i < `NUM_COUNTERS; i++) begin
                count_val_q[i] <= `CLEAR_VALUE; // R15
            end
        end else begin
            for (int i = 0; i < `NUM_COUNTERS; i++) begin
                if (counter_cmd.valid && counter_cmd.clear
                        && counter_index == `COUNTER_IDX_W'(i)) begin
                    count_val_q[i] <= `CLEAR_VALUE; // R8
                    count_done_q[i] <= 1'b0; // R8
                end else if (counter_cmd.valid && counter_cmd.load
                        && counter_index == `COUNTER_IDX_W'(i)) begin
                    count_val_q[i] <= counter_cmd.load_value;
                end else if (count_level[i] && !count_prev_q[i] && !count_done_q[i]) begin // R6
                    // Loaded value past the set snaps to the set at the edge
                    if (reached_set(count_val_q[i], count_set_q[i])) begin
                        count_val_q[i] <= count_set_q[i]; // R11 R10
                        count_done_q[i] <= 1'b1; // R7
                    end else begin
                        count_val_q[i] <= count_val_q[i] + 16'h0001; // R4 R12
                    end
                end
                // Done counters hold their value: only a clear or load command updates them
            end
        end
    end

    // Counter contacts only change at scan end, so one scan sees one state
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            counter_contacts <= '0;
        end else if (scan_end) begin
            counter_contacts <= count_done_q; // R9
        end
    end

    // Readback of the addressed counter and timer
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            counter_value_out <= `CLEAR_VALUE;
            timer_value_out <= `CLEAR_VALUE;
        end else begin
            counter_value_out <= count_val_q[counter_index];
            timer_value_out <= timer_val_q[timer_index];
        end
    end

    // R14 is kept by the executor; any nonzero register value is taken as given

    // Counter 0 and timer 0 stand for the whole bank; the bench drives both
    a_contact_scan: assert property (@(posedge mclk) disable iff (reset) // R9
        !$past(scan_end) |-> $stable(counter_contacts))
        else $error("counter contact changed outside scan end");

    a_scan_publish: assert property (@(posedge mclk) disable iff (reset) // R9
        scan_end |=> counter_contacts == $past(count_done_q))
        else $error("contacts not published at scan end");

    a_contact_on: assert property (@(posedge mclk) disable iff (reset) // R7
        (count_done_q[0] && scan_end) |=> counter_contacts[0])
        else $error("reached counter contact not on after scan");

    a_done_holds: assert property (@(posedge mclk) disable iff (reset) // R6
        (count_done_q[0] && !(counter_cmd.valid && counter_index == 6'h00))
        |=> count_val_q[0] == $past(count_val_q[0]))
        else $error("done counter moved");

    a_clear_zero: assert property (@(posedge mclk) disable iff (reset) // R8
        (counter_cmd.valid && counter_cmd.clear && counter_index == 6'h00)
        |=> count_val_q[0] == 16'h0000 && !count_done_q[0])
        else $error("clear did not zero counter");

    a_done_sticky: assert property (@(posedge mclk) disable iff (reset) // R7
        (count_done_q[0] && !(counter_cmd.valid && counter_cmd.clear
         && counter_index == 6'h00)) |=> count_done_q[0])
        else $error("counter contact dropped without clear");

    a_done_equal: assert property (@(posedge mclk) disable iff (reset) // R6
        $rose(count_done_q[0]) |-> count_val_q[0] == count_set_q[0])
        else $error("counter done with value off set");

    a_count_step: assert property (@(posedge mclk) disable iff (reset) // R4
        (count_level[0] && !count_prev_q[0] && !count_done_q[0] && !counter_cmd.valid
         && !reached_set(count_val_q[0], count_set_q[0]))
        |=> count_val_q[0] == $past(count_val_q[0]) + 16'h0001)
        else $error("counter did not add one");

    a_count_snap: assert property (@(posedge mclk) disable iff (reset) // R11
        (count_level[0] && !count_prev_q[0] && !count_done_q[0] && !counter_cmd.valid
         && reached_set(count_val_q[0], count_set_q[0]))
        |=> count_done_q[0] && count_val_q[0] == $past(count_set_q[0]))
        else $error("counter did not stop at set");

    a_count_wrap: assert property (@(posedge mclk) disable iff (reset) // R12
        (count_level[0] && !count_prev_q[0] && !count_done_q[0] && !counter_cmd.valid
         && count_val_q[0] == 16'h7fff && count_set_q[0][15] && count_set_q[0] != 16'h8000)
        |=> count_val_q[0] == 16'h8000)
        else $error("counter did not wrap to negative");

    a_set_nonzero: assert property (@(posedge mclk) disable iff (reset) // R10
        count_set_q[0] != 16'h0000 && timer_set_q[0] != 16'h0000)
        else $error("set value of zero stored");

    a_imm_range: assert property (@(posedge mclk) disable iff (reset) // R13
        (counter_cmd.valid && counter_cmd.source == src_immediate && counter_index == 6'h00)
        |=> !count_set_q[0][15])
        else $error("immediate set value above range");

    a_power_clear: assert property (@(posedge mclk) disable iff (reset) // R15
        $fell(reset) |-> count_val_q[0] == 16'h0000 && counter_value_out == 16'h0000)
        else $error("counter not cleared at power up");

    // Timer checks
    a_timer_step: assert property (@(posedge mclk) disable iff (reset) // R1
        (!tick && timer_run_q[0] && $past(timer_run_q[0]))
        |=> timer_val_q[0] == $past(timer_val_q[0]))
        else $error("timer advanced without tick");

    a_timer_tick: assert property (@(posedge mclk) disable iff (reset) // R1
        (tick && timer_run_q[0] && timer_val_q[0] != timer_set_q[0])
        |=> timer_val_q[0] == $past(timer_val_q[0]) + 16'h0001)
        else $error("timer missed a tick");

    a_timer_hold: assert property (@(posedge mclk) disable iff (reset) // R2
        (timer_run_q[0] && timer_val_q[0] == timer_set_q[0] && !timer_cmd_valid)
        |=> timer_val_q[0] == $past(timer_val_q[0]))
        else $error("timer moved past its set value");

    a_timer_contact: assert property (@(posedge mclk) disable iff (reset) // R2
        (timer_run_q[0] && timer_val_q[0] == timer_set_q[0]) |=> timer_contacts[0])
        else $error("timer contact missing");

    a_timer_off: assert property (@(posedge mclk) disable iff (reset) // R2
        !timer_run_q[0] |=> timer_val_q[0] == 16'h0000 && !timer_contacts[0])
        else $error("disabled timer not cleared");
endmodule // plc_timer_counter_bank
`default_nettype wire

// ===== dv/scan_executor_model.sv
// Purpose: program scan executor stand-in that marks the end of each scan
// Assumes: one clock shared with the bank
// Notes: scans pause while run is low so a test can hold contacts still
`timescale 1ns/1ps
`default_nettype none
module scan_executor_model #(
    parameter int unsigned SCAN_CYCLES = 16
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic run,
    output logic scan_end
);
    logic [7:0] count_q;
    // One-cycle end-of-scan pulse every SCAN_CYCLES while running
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_q <= 8'h00;
            scan_end <= 1'b0;
        end else begin
            scan_end <= run && (count_q == 8'(SCAN_CYCLES - 1));
            count_q <= (count_q == 8'(SCAN_CYCLES - 1)) ? 8'h00 : count_q + 8'h01;
        end
    end
endmodule // scan_executor_model
`default_nettype wire

// ===== dv/plc_timer_counter_bank_tb.sv
// Purpose: self-checking bench for the timer and counter bank
// Assumes: short tick period of 10 cycles
// Notes: scans are paused while counting so contact timing is observable
`timescale 1ns/1ps
`default_nettype none
module plc_timer_counter_bank_tb;
    import plc_tc_pkg::*;
    localparam int TICK = 10;
    localparam int SCAN = 16;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic timer_cmd_valid = 1'b0;
    logic [6:0] timer_index = 7'h00;
    logic timer_enable = 1'b0;
    set_source_type timer_source = src_immediate;
    logic [15:0] timer_set_value = 16'h0000;
    logic [5:0] counter_index = 6'h00;
    cmd_type counter_cmd = '0;
    logic [39:0] count_pins = 40'h0;
    logic run = 1'b0;
    logic scan_end;
    logic [79:0] timer_contacts;
    logic [39:0] counter_contacts;
    logic [15:0] counter_value_out;
    logic [15:0] timer_value_out;
    int bad_count = 0;
    int num_checks = 0;
    // Clock at 10 MHz
    always #50 mclk = ~mclk;
    plc_timer_counter_bank #(.TICK_CYCLES(TICK)) i_plc_timer_counter_bank (
        .mclk(mclk), .reset(reset), .timer_cmd_valid(timer_cmd_valid),
        .timer_index(timer_index), .timer_enable(timer_enable),
        .timer_source(timer_source), .timer_set_value(timer_set_value),
        .counter_index(counter_index), .counter_cmd(counter_cmd),
        .count_pins(count_pins), .scan_end(scan_end), .timer_contacts(timer_contacts),
        .counter_contacts(counter_contacts), .counter_value_out(counter_value_out),
        .timer_value_out(timer_value_out));
    scan_executor_model #(.SCAN_CYCLES(SCAN)) i_scan_executor_model (
        .mclk(mclk), .reset(reset), .run(run), .scan_end(scan_end));
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One counter command; every command carries the set value
    task automatic cmd(input logic clr, input logic ld, input set_source_type src,
                       input logic [15:0] setv, input logic [15:0] ldv);
        counter_cmd = '{valid: 1'b1, clear: clr, load: ld, source: src,
                        set_value: setv, load_value: ldv};
        step(1);
        counter_cmd.valid = 1'b0;
        step(1);
    endtask
    // Rising edges on the selected counting pin, slow enough for the synchroniser
    task automatic pulse(input int n);
        repeat (n) begin
            count_pins[counter_index] = 1'b1;
            step(4);
            count_pins[counter_index] = 1'b0;
            step(4);
        end
    endtask
    // Let at least two scans finish, then freeze scanning again
    task automatic scans();
        run = 1'b1;
        step(2 * SCAN + 2);
        run = 1'b0;
        step(2);
    endtask
    task automatic timer_delay();
        int n;
        n = 0;
        timer_set_value = 16'h0005;
        timer_enable = 1'b1;
        timer_cmd_valid = 1'b1;
        step(1);
        timer_cmd_valid = 1'b0;
        step(3 * TICK);
        chk(16'(timer_contacts[0]), 16'h0000);
        while (timer_contacts[0] !== 1'b1 && n < 8 * TICK) begin
            step(1);
            n++;
        end
        // Contact lands 4*TICK+2 to 5*TICK+1 cycles after the command; 30 already spent
        chk(16'(n >= 4 * TICK - 28 && n <= 5 * TICK - 29), 16'h0001);
        chk(timer_value_out, 16'h0005);
    endtask
    task automatic counter_basic();
        counter_index = 6'h00;
        cmd(1'b1, 1'b0, src_immediate, 16'h0005, 16'h0000);
        pulse(6);
        chk(counter_value_out, 16'h0005);
        chk(16'(counter_contacts[0]), 16'h0000);
        scans();
        chk(16'(counter_contacts[0]), 16'h0001);
        pulse(1);
        chk(counter_value_out, 16'h0005);
        cmd(1'b1, 1'b0, src_immediate, 16'h0005, 16'h0000);
        chk(counter_value_out, 16'h0000);
        scans();
        chk(16'(counter_contacts[0]), 16'h0000);
        pulse(2);
        chk(counter_value_out, 16'h0002);
    endtask
    task automatic counter_corners();
        counter_index = 6'h06;
        cmd(1'b1, 1'b0, src_immediate, 16'h0000, 16'h0000);
        pulse(1);
        scans();
        chk(16'(counter_contacts[6]), 16'h0001);
        counter_index = 6'h07;
        cmd(1'b1, 1'b0, src_immediate, 16'h0004, 16'h0000);
        cmd(1'b0, 1'b1, src_immediate, 16'h0004, 16'h0009);
        pulse(1);
        chk(counter_value_out, 16'h0004);
        scans();
        chk(16'(counter_contacts[7]), 16'h0001);
        counter_index = 6'h08;
        cmd(1'b1, 1'b0, src_immediate, 16'h8003, 16'h0000);
        pulse(2);
        scans();
        chk(16'(counter_contacts[8]), 16'h0000);
        pulse(1);
        chk(counter_value_out, 16'h0003);
        counter_index = 6'h09;
        // Set value from a general data register, never the special ranges
        cmd(1'b1, 1'b0, src_register, 16'h0002, 16'h0000);
        pulse(2);
        scans();
        chk(16'(counter_contacts[9]), 16'h0001);
        // Negative register set: the count climbs through the wrap to reach it
        counter_index = 6'h00;
        cmd(1'b1, 1'b0, src_register, 16'h8001, 16'h0000);
        cmd(1'b0, 1'b1, src_register, 16'h8001, 16'h7fff);
        pulse(1);
        chk(counter_value_out, 16'h8000);
        pulse(1);
        chk(counter_value_out, 16'h8001);
        scans();
        chk(16'(counter_contacts[0]), 16'h0001);
    endtask
    task automatic power_loss();
        reset = 1'b1;
        step(3);
        reset = 1'b0;
        step(2);
        chk(counter_value_out, 16'h0000);
        chk(counter_contacts[15:0], 16'h0000);
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        step(3);
        reset = 1'b0;
        step(1);
        timer_delay();
        counter_basic();
        counter_corners();
        power_loss();
        report_and_stop();
    end
    // Watchdog well beyond the expected run of about 470 cycles
    initial begin
        #(6000 * 100);
        bad_count++;
        report_and_stop();
    end
endmodule // plc_timer_counter_bank_tb
`default_nettype wire
